//--- inc/ecc_pkg.sv
// Constants and types shared by the byte stream code generator
package ecc_pkg;
   localparam int ECC_ADDR_W = 5;
   localparam int CNT_W = 9;
   localparam int LINE_W = 9;
   localparam int COL_W = 3;
   localparam int CODE_W = 24;
   // Register byte addresses
   localparam logic [ECC_ADDR_W-1:0] OFS_CFG = 5'h00;
   localparam logic [ECC_ADDR_W-1:0] OFS_RESTART = 5'h04;
   localparam logic [ECC_ADDR_W-1:0] OFS_C1B0 = 5'h08;
   localparam logic [ECC_ADDR_W-1:0] OFS_C1B1 = 5'h0C;
   localparam logic [ECC_ADDR_W-1:0] OFS_C1B2 = 5'h10;
   localparam logic [ECC_ADDR_W-1:0] OFS_C2B0 = 5'h14;
   localparam logic [ECC_ADDR_W-1:0] OFS_C2B1 = 5'h18;
   localparam logic [ECC_ADDR_W-1:0] OFS_C2B2 = 5'h1C;
   localparam int CFG_MODE_BIT = 0;
   localparam logic CFG_MODE_RESET = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   localparam logic [7:0] LAST_256 = 8'hFF;
   localparam logic [CNT_W-1:0] LAST_512 = 9'h1FF;
   localparam logic [1:0] LOW_BITS_256 = 2'h3;
   localparam logic [CODE_W-1:0] CODE_RESET = 24'h000000;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Data bits whose bit index has index bit k set
   localparam logic [COL_W-1:0][7:0] COL_MASK = {8'hF0, 8'hCC, 8'hAA};
   typedef enum logic [2:0] {
      st_first = 3'b001,
      st_second = 3'b010,
      st_done = 3'b100
   } blk_state_type;
endpackage

//--- rtl/byte_stream_hamming_ecc.sv
// Byte stream error correcting code generator with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module byte_stream_hamming_ecc
   import ecc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ECC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ECC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic codes_complete
);
   logic aw_have_ff;
   logic [ECC_ADDR_W-1:0] awaddr_ff;
   logic w_have_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic block_size_select_ff;
   blk_state_type state_ff;
   blk_state_type nxt_state;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic [CODE_W-1:0] first_code_result_set_ff;
   logic [CODE_W-1:0] second_code_result_set_ff;
   logic [LINE_W-1:0] line_true;
   logic [LINE_W-1:0] line_comp;
   logic [COL_W-1:0] col_true;
   logic [COL_W-1:0] col_comp;
   logic [7:0] code_b0;
   logic [7:0] code_b1;
   logic [7:0] code_b2;

   // Write channel decode
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_have_ff && w_have_ff;
   wire wr_cfg = do_write && (awaddr_ff == OFS_CFG);
   wire wr_restart = do_write && (awaddr_ff == OFS_RESTART);
   wire wr_result = (awaddr_ff == OFS_C1B0) || (awaddr_ff == OFS_C1B1) ||
      (awaddr_ff == OFS_C1B2) || (awaddr_ff == OFS_C2B0) || (awaddr_ff == OFS_C2B1) ||
      (awaddr_ff == OFS_C2B2);
   wire wr_mapped = (awaddr_ff == OFS_CFG) || (awaddr_ff == OFS_RESTART) || wr_result;
   assign s_axi_awready = !aw_have_ff && !bvalid_ff;
   assign s_axi_wready = !w_have_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // Read channel decode
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire [7:0] rd_byte =
      (s_axi_araddr == OFS_CFG) ? {7'h00, block_size_select_ff} :
      (s_axi_araddr == OFS_C1B0) ? first_code_result_set_ff[23:16] :
      (s_axi_araddr == OFS_C1B1) ? first_code_result_set_ff[15:8] :
      (s_axi_araddr == OFS_C1B2) ? first_code_result_set_ff[7:0] :
      (s_axi_araddr == OFS_C2B0) ? second_code_result_set_ff[23:16] :
      (s_axi_araddr == OFS_C2B1) ? second_code_result_set_ff[15:8] :
      (s_axi_araddr == OFS_C2B2) ? second_code_result_set_ff[7:0] : 8'h00;
   wire rd_mapped = (s_axi_araddr == OFS_CFG) || (s_axi_araddr == OFS_RESTART) ||
      (s_axi_araddr == OFS_C1B0) || (s_axi_araddr == OFS_C1B1) ||
      (s_axi_araddr == OFS_C1B2) || (s_axi_araddr == OFS_C2B0) ||
      (s_axi_araddr == OFS_C2B1) || (s_axi_araddr == OFS_C2B2);
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         awaddr_ff <= '0;
         w_have_ff <= 1'b0;
         wdata_ff <= RDATA_ZERO;
         wstrb_ff <= 4'h0;
      end else begin
         aw_have_ff <= (aw_have_ff || aw_fire) && !do_write;
         w_have_ff <= (w_have_ff || w_fire) && !do_write;
         if (aw_fire) begin
            awaddr_ff <= s_axi_awaddr;
         end
         if (w_fire) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= RDATA_ZERO;
         rresp_ff <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= {24'h000000, rd_byte};
         rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_size_select_ff <= CFG_MODE_RESET;
      end else if (wr_cfg && wstrb_ff[0]) begin
         block_size_select_ff <= wdata_ff[CFG_MODE_BIT];
      end
   end

   // Block sequencing
   wire acc_valid = byte_valid && (state_ff != st_done);
   wire last_byte = block_size_select_ff ? (count_ff == LAST_512) :
      (count_ff[7:0] == LAST_256);
   wire blk_end = acc_valid && last_byte && !wr_restart;
   wire acc_clear = wr_restart || blk_end;
   assign codes_complete = (state_ff == st_done);

   always_comb begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      if (wr_restart) begin
         nxt_state = st_first;
         nxt_count = CNT_RESET;
      end else if (acc_valid) begin
         nxt_count = count_ff + CNT_ONE;
         if (blk_end) begin
            unique case (state_ff)
               st_first: nxt_state = block_size_select_ff ? st_done : st_second;
               st_second: nxt_state = st_done;
               st_done: nxt_state = st_done;
               default: nxt_state = st_done;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= st_first;
         count_ff <= CNT_RESET;
      end else begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
      end
   end

   hamming_accumulator i_hamming_accumulator (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(acc_clear),
      .byte_valid(acc_valid && !wr_restart),
      .byte_data(byte_data),
      .byte_offset(count_ff),
      .line_true(line_true),
      .line_comp(line_comp),
      .col_true(col_true),
      .col_comp(col_comp)
   );

   // Code byte assembly from parity pairs
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_line_pairs
         assign code_b0[2*i+1] = line_true[4+i];
         assign code_b0[2*i] = line_comp[4+i];
         assign code_b1[2*i+1] = line_true[i];
         assign code_b1[2*i] = line_comp[i];
      end
      for (i = 0; i < COL_W; i++) begin : g_col_pairs
         assign code_b2[2*i+3] = col_true[i];
         assign code_b2[2*i+2] = col_comp[i];
      end
   endgenerate
   assign code_b2[1:0] = block_size_select_ff ? {line_true[8], line_comp[8]} :
      LOW_BITS_256;
   wire [CODE_W-1:0] code_word = {code_b0, code_b1, code_b2};

   always_ff @(posedge aclk) begin
      if (!aresetn || wr_restart) begin
         first_code_result_set_ff <= CODE_RESET;
         second_code_result_set_ff <= CODE_RESET;
      end else if (blk_end && state_ff == st_first) begin
         first_code_result_set_ff <= code_word;
      end else if (blk_end && state_ff == st_second) begin
         second_code_result_set_ff <= code_word;
      end
   end

   // Checks
   property p_restart_clears;
      @(posedge aclk) disable iff (!aresetn)
      wr_restart |=> count_ff == CNT_RESET && state_ff == st_first && first_code_result_set_ff == CODE_RESET;
   endproperty
   a_restart_clears: assert property (p_restart_clears) else $error("restart ignored");

   property p_count_step;
      @(posedge aclk) disable iff (!aresetn)
      acc_valid && !wr_restart |=> count_ff == $past(count_ff) + CNT_ONE;
   endproperty
   a_count_step: assert property (p_count_step) else $error("byte not counted");

   property p_hold_done;
      @(posedge aclk) disable iff (!aresetn)
      state_ff == st_done && !wr_restart |=> $stable(first_code_result_set_ff) && $stable(second_code_result_set_ff);
   endproperty
   a_hold_done: assert property (p_hold_done) else $error("result changed");

   property p_first_store;
      @(posedge aclk) disable iff (!aresetn)
      blk_end && state_ff == st_first |=> first_code_result_set_ff == $past(code_word) && $stable(second_code_result_set_ff);
   endproperty
   a_first_store: assert property (p_first_store) else $error("first code lost");

   property p_second_after_256;
      @(posedge aclk) disable iff (!aresetn)
      blk_end && state_ff == st_first && !block_size_select_ff |=> state_ff == st_second;
   endproperty
   a_second_after_256: assert property (p_second_after_256) else $error("no second block");

   property p_512_single;
      @(posedge aclk) disable iff (!aresetn)
      blk_end && block_size_select_ff |-> count_ff == LAST_512 ##1
         (state_ff == st_done && $stable(second_code_result_set_ff));
   endproperty
   a_512_single: assert property (p_512_single) else $error("512 block wrong");

   property p_low_bits_256;
      @(posedge aclk) disable iff (!aresetn)
      blk_end && !block_size_select_ff |=> (state_ff == st_second ? first_code_result_set_ff[1:0] :
         second_code_result_set_ff[1:0]) == LOW_BITS_256;
   endproperty
   a_low_bits_256: assert property (p_low_bits_256) else $error("low bits not 11");

   property p_pairs_agree;
      @(posedge aclk) disable iff (!aresetn)
      (line_true ^ line_comp) == {LINE_W{col_true[0] ^ col_comp[0]}} &&
         (col_true ^ col_comp) == {COL_W{col_true[0] ^ col_comp[0]}};
   endproperty
   a_pairs_agree: assert property (p_pairs_agree) else $error("parity pair mismatch");

   property p_cfg_readback;
      @(posedge aclk) disable iff (!aresetn)
      ar_fire && s_axi_araddr == OFS_CFG |=> rdata_ff == {31'h0, block_size_select_ff};
   endproperty
   a_cfg_readback: assert property (p_cfg_readback) else $error("config read wrong");

   property p_write_resp;
      @(posedge aclk) disable iff (!aresetn)
      do_write |=> bvalid_ff ##0 !aw_have_ff && !w_have_ff;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("write not answered");

   property p_second_store;
      @(posedge aclk) disable iff (!aresetn)
      blk_end && state_ff == st_second |=> second_code_result_set_ff == $past(code_word) && $stable(first_code_result_set_ff);
   endproperty
   a_second_store: assert property (p_second_store) else $error("second code lost");

   property p_done_ignores;
      @(posedge aclk) disable iff (!aresetn)
      state_ff == st_done && !wr_restart |=> state_ff == st_done && $stable(count_ff);
   endproperty
   a_done_ignores: assert property (p_done_ignores) else $error("late byte taken");

   // Offset bit 8 pair must differ exactly as the column pairs do
   property p_512_pair;
      @(posedge aclk) disable iff (!aresetn)
      blk_end && block_size_select_ff && state_ff == st_first |=>
         (first_code_result_set_ff[1] ^ first_code_result_set_ff[0]) == (first_code_result_set_ff[3] ^ first_code_result_set_ff[2]);
   endproperty
   a_512_pair: assert property (p_512_pair) else $error("offset bit 8 pair broken");

   property p_cfg_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_cfg && wstrb_ff[0] |=> block_size_select_ff == $past(wdata_ff[CFG_MODE_BIT]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

   property p_restart_rd0;
      @(posedge aclk) disable iff (!aresetn)
      ar_fire && s_axi_araddr == OFS_RESTART |=> rdata_ff == RDATA_ZERO;
   endproperty
   a_restart_rd0: assert property (p_restart_rd0) else $error("restart readable");

   property p_unmapped_write;
      @(posedge aclk) disable iff (!aresetn)
      do_write && !wr_mapped |=> bvalid_ff && bresp_ff == RESP_SLVERR;
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write accepted");

   c_two_blocks: cover property (@(posedge aclk) disable iff (!aresetn)
      blk_end && state_ff == st_second);
   c_512_block: cover property (@(posedge aclk) disable iff (!aresetn)
      blk_end && block_size_select_ff);
   c_restart_mid: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_restart && count_ff != CNT_RESET);
   c_bytes_after_done: cover property (@(posedge aclk) disable iff (!aresetn)
      byte_valid && state_ff == st_done);
endmodule
`default_nettype wire

//--- rtl/hamming_accumulator.sv
// Running line and column parity pairs over a byte stream
`timescale 1ns/100ps
`default_nettype none
module hamming_accumulator
   import ecc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic [LINE_W-1:0] byte_offset,
   output logic [LINE_W-1:0] line_true,
   output logic [LINE_W-1:0] line_comp,
   output logic [COL_W-1:0] col_true,
   output logic [COL_W-1:0] col_comp
);
   logic [LINE_W-1:0] line_true_ff;
   logic [LINE_W-1:0] line_comp_ff;
   logic [COL_W-1:0] col_true_ff;
   logic [COL_W-1:0] col_comp_ff;
   wire byte_par = ^byte_data;

   // Outputs include the byte of this cycle
   genvar j;
   generate
      for (j = 0; j < LINE_W; j++) begin : g_line
         assign line_true[j] = line_true_ff[j] ^ (byte_valid & byte_par & byte_offset[j]);
         assign line_comp[j] = line_comp_ff[j] ^ (byte_valid & byte_par & ~byte_offset[j]);
      end
      for (j = 0; j < COL_W; j++) begin : g_col
         assign col_true[j] = col_true_ff[j] ^ (byte_valid & (^(byte_data & COL_MASK[j])));
         assign col_comp[j] = col_comp_ff[j] ^ (byte_valid & (^(byte_data & ~COL_MASK[j])));
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         line_true_ff <= '0;
         line_comp_ff <= '0;
         col_true_ff <= '0;
         col_comp_ff <= '0;
      end else begin
         line_true_ff <= line_true;
         line_comp_ff <= line_comp;
         col_true_ff <= col_true;
         col_comp_ff <= col_comp;
      end
   end

   property p_offset_parity;
      @(posedge aclk) disable iff (!aresetn)
      byte_valid && !clear |=> line_true_ff == ($past(line_true_ff) ^
         ($past(byte_offset) & {LINE_W{$past(byte_par)}}));
   endproperty
   a_offset_parity: assert property (p_offset_parity) else $error("line parity wrong");
endmodule
`default_nettype wire

//--- tb/byte_source.sv
// Byte stream source standing in for the byte-wide datapath
`timescale 1ns/100ps
`default_nettype none
module byte_source (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic [9:0] n_bytes,
   output logic byte_valid = 1'b0,
   output logic [7:0] byte_data = 8'h00,
   output logic busy = 1'b0
);
   int left;
   // Byte wide only, random gaps; idle data toggles so nothing stale looks valid
   always @(posedge aclk) begin
      if (!aresetn) begin
         left = 0;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
      end else begin
         if (go) left = n_bytes;
         if (left > 0 && $urandom_range(3) != 0) begin
            byte_valid <= 1'b1;
            byte_data <= 8'($urandom);
            left--;
         end else begin
            byte_valid <= 1'b0;
            byte_data <= ~byte_data;
         end
      end
      busy <= left > 0;
   end
endmodule
`default_nettype wire

//--- tb/test_byte_stream_hamming_ecc.sv
// Self-checking bench for the byte stream code generator
`timescale 1ns/100ps
`default_nettype none
module test_byte_stream_hamming_ecc
   import ecc_pkg::*;
;
   typedef struct {string nm; logic [33:0] v;} note_type;
   localparam int LIMIT = 20000;
   logic aclk = 1'b0;
   logic aresetn, go, byte_valid, codes_complete, busy;
   logic [ECC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] byte_data;
   logic [9:0] n_bytes;
   logic [7:0] sent[$];
   note_type exp_q[$];
   note_type nt;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   int flip;
   logic [23:0] pairs;
   logic [10:0] loc;

   byte_stream_hamming_ecc i_byte_stream_hamming_ecc (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .byte_valid, .byte_data,
      .codes_complete);
   byte_source i_byte_source (.aclk, .aresetn, .go, .n_bytes, .byte_valid, .byte_data, .busy);

   always #12.5 aclk = ~aclk;

   task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Watcher: every bus answer is matched against the oldest note
   always @(posedge aclk) begin
      if (byte_valid) sent.push_back(byte_data);
      if (aresetn && ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))) begin
         nt = exp_q.pop_front();
         check(nt.nm, nt.v, s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0});
      end
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         results();
      end
   end

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      logic haw, hw, hb;
      exp_q.push_back('{"bresp", {r, 32'h0}});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(negedge aclk);
         haw = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid && s_axi_bready;
         @(posedge aclk);
         if (haw) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r = RESP_OKAY, input string nm = "rdata");
      logic har, hr;
      exp_q.push_back('{nm, {r, d}});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(negedge aclk);
         har = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid && s_axi_rready;
         @(posedge aclk);
         if (har) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic send(input int n);
      n_bytes <= 10'(n);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (2) @(posedge aclk);
      while (busy) @(posedge aclk);
      repeat (3) @(posedge aclk);
   endtask

   // Reference code: true/complement pairs of line and column parity
   function automatic logic [23:0] code_of(input int base, input int len, input logic m1);
      logic [8:0] lt, lc;
      logic [2:0] ct, cc;
      logic [7:0] b;
      logic [7:0] cm [3] = '{8'hAA, 8'hCC, 8'hF0};
      lt = '0;
      lc = '0;
      ct = '0;
      cc = '0;
      for (int i = 0; i < len; i++) begin
         b = sent[base + i];
         for (int k = 0; k < 9; k++) begin
            if (i[k]) lt[k] ^= ^b;
            else lc[k] ^= ^b;
         end
         for (int k = 0; k < 3; k++) begin
            ct[k] ^= ^(b & cm[k]);
            cc[k] ^= ^(b & ~cm[k]);
         end
      end
      return {lt[7], lc[7], lt[6], lc[6], lt[5], lc[5], lt[4], lc[4],
              lt[3], lc[3], lt[2], lc[2], lt[1], lc[1], lt[0], lc[0],
              ct[2], cc[2], ct[1], cc[1], ct[0], cc[0], m1 ? {lt[8], lc[8]} : 2'b11};
   endfunction

   task automatic check_set(input logic [4:0] a, input logic [23:0] c);
      rd(a, {24'h0, c[23:16]}, RESP_OKAY, "code byte 0");
      rd(a + 5'h04, {24'h0, c[15:8]}, RESP_OKAY, "code byte 1");
      rd(a + 5'h08, {24'h0, c[7:0]}, RESP_OKAY, "code byte 2");
   endtask

   initial begin
      aresetn = 1'b0;
      go = 1'b0;
      n_bytes = 10'h000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'h8E30B93A));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_CFG, 32'h0, RESP_OKAY, "config");
      rd(OFS_C2B2, 32'h0);
      rd(OFS_RESTART, 32'h0, RESP_OKAY, "restart");
      wr(5'h02, $urandom, RESP_SLVERR);
      rd(5'h02, 32'h0, RESP_SLVERR, "unmapped");
      for (int m = 0; m < 2; m++) begin
         wr(OFS_CFG, ($urandom & 32'hFFFFFFFE) | 32'(m));
         rd(OFS_CFG, 32'(m), RESP_OKAY, "config");
         send(100);
         wr(OFS_RESTART, $urandom);
         sent.delete();
         check("complete", 34'h0, {33'h0, codes_complete});
         rd(OFS_C1B0, 32'h0);
         send(256);
         if (m == 0) begin
            check_set(OFS_C1B0, code_of(0, 256, 1'b0));
            // Software check of a one-bit data error against the reference code
            flip = $urandom_range(2047);
            pairs = code_of(0, 256, 1'b0);
            sent[flip / 8] = sent[flip / 8] ^ (8'h01 << (flip % 8));
            pairs ^= code_of(0, 256, 1'b0);
            sent[flip / 8] = sent[flip / 8] ^ (8'h01 << (flip % 8));
            loc = {pairs[23], pairs[21], pairs[19], pairs[17], pairs[15], pairs[13], pairs[11],
                   pairs[9], pairs[7], pairs[5], pairs[3]};
            check("error locate", 34'(flip), {23'h0, loc});
            pairs = (pairs ^ (pairs >> 1)) & 24'h555554;
            check("pair test", 34'h555554, {10'h0, pairs});
         end
         send(300);
         check_set(OFS_C1B0, code_of(0, m ? 512 : 256, m[0]));
         check_set(OFS_C2B0, m ? 24'h0 : code_of(256, 256, 1'b0));
         check("complete", 34'h1, {33'h0, codes_complete});
      end
      results();
   end
endmodule
`default_nettype wire
